// [hdl/bxs_pkg.sv]
// Operation
// - Register-subtract yields file register minus accumulator.
// - Carry set when accumulator not greater; half flag when its low nibble not greater.
// - Select bit zero targets accumulator, one targets register.
// - Seven-bit register address and one-bit select.
// - Immediate XOR writes accumulator, updates zero only.
// - Nibble exchange swaps halves, leaves flags alone.
// - Register XOR routed by select, zero only.
package bxs_pkg;

  // ==========================================================================
  // Register map (byte addresses on the bus)
  // ==========================================================================
  localparam int unsigned BXS_AW = 12;
  localparam logic [11:0] BXS_CMD_OFS = 12'h000;
  localparam logic [11:0] BXS_ACC_OFS = 12'h004;
  localparam logic [11:0] BXS_STAT_OFS = 12'h008;
  localparam logic [11:0] BXS_RES_OFS = 12'h00c;
  localparam logic [11:0] BXS_FILE_BASE = 12'h200;
  localparam int unsigned BXS_FILE_TAG_LSB = 9;
  localparam logic [2:0] BXS_FILE_TAG = 3'h1;
  localparam int unsigned BXS_FILE_IDX_LSB = 2;
  localparam int unsigned BXS_FILE_DEPTH = 128;

  // ==========================================================================
  // Command word fields
  // ==========================================================================
  localparam int unsigned BXS_CMD_OP_LSB = 0;
  localparam int unsigned BXS_CMD_DEST_BIT = 2;
  localparam int unsigned BXS_CMD_FADDR_LSB = 8;
  localparam int unsigned BXS_CMD_IMM_LSB = 16;

  // ==========================================================================
  // Status bits and reset values
  // ==========================================================================
  localparam int unsigned BXS_ST_CARRY = 0;
  localparam int unsigned BXS_ST_HALF = 1;
  localparam int unsigned BXS_ST_ZERO = 2;
  localparam logic [7:0] BXS_ACC_RST = 8'h00;
  localparam logic [7:0] BXS_FILE_RST = 8'h00;
  localparam logic [2:0] BXS_FLAGS_RST = 3'h0;
  localparam logic [31:0] BXS_RDATA_RST = 32'h0000_0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    register_minus_accumulator_op,
    immediate_xor_op,
    nibble_exchange_op,
    register_xor_op
  } bxs_op_t;

  typedef struct packed {
    logic zero;
    logic half_borrow_inverse_flag;
    logic carry;
  } bxs_flags_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [6:0] faddr;
    logic dest;
    bxs_op_t op;
  } bxs_cmd_t;

  typedef struct packed {
    logic [7:0] result;
    bxs_flags_t flags;
    logic to_file;
  } bxs_alu_out_t;

endpackage

// [hdl/bxs_alu.sv]
`timescale 1ns/1ps
module bxs_alu
  import bxs_pkg::*;
(
  input bxs_cmd_t cmd,
  input logic [7:0] acc,
  input logic [7:0] freg_val,
  input bxs_flags_t flags_in,
  output bxs_alu_out_t alu_out
);

  logic [8:0] diff;

  always_comb begin
    diff = {1'b0, freg_val} - {1'b0, acc};
    alu_out.flags = flags_in;
    alu_out.to_file = cmd.dest;
    unique case (cmd.op)
      register_minus_accumulator_op: begin
        alu_out.result = diff[7:0];
        // No borrow out of bit 8 means the accumulator did not exceed the register.
        alu_out.flags.carry = ~diff[8];
        alu_out.flags.half_borrow_inverse_flag = (acc[3:0] <= freg_val[3:0]);
        alu_out.flags.zero = (diff[7:0] == 8'h00);
      end
      immediate_xor_op: begin
        alu_out.result = acc ^ cmd.imm;
        alu_out.to_file = 1'b0;
        alu_out.flags.zero = ((acc ^ cmd.imm) == 8'h00);
      end
      nibble_exchange_op: begin
        alu_out.result = {freg_val[3:0], freg_val[7:4]};
      end
      register_xor_op: begin
        alu_out.result = acc ^ freg_val;
        alu_out.flags.zero = ((acc ^ freg_val) == 8'h00);
      end
    endcase
  end

endmodule

// [hdl/bxs_top.sv]
`timescale 1ns/1ps
module bxs_top
  import bxs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [BXS_FILE_DEPTH-1:0][7:0] freg;
    logic [7:0] acc;
    bxs_flags_t flags;
    logic [7:0] last_result;
    logic pend;
    logic wr;
    logic [11:0] addr;
    logic hreadyout;
    logic [31:0] hrdata;
  } bxs_state_t;

  bxs_state_t st;
  bxs_state_t next_st;
  bxs_cmd_t cmd;
  bxs_alu_out_t alu_out;
  logic [7:0] sel_freg;

  // ==========================================================================
  // Address decode and register words
  // ==========================================================================
  typedef enum logic [2:0] {
    reg_none,
    reg_cmd,
    reg_acc,
    reg_stat,
    reg_res,
    reg_file
  } bxs_reg_t;

  bxs_reg_t reg_sel;
  logic accept;

  function automatic logic bxs_is_file(input logic [11:0] a);
    return a[11:BXS_FILE_TAG_LSB] == BXS_FILE_TAG;
  endfunction

  function automatic logic [6:0] bxs_file_idx(input logic [11:0] a);
    return a[BXS_FILE_IDX_LSB +: 7];
  endfunction

  // Offsets outside the map decode to none: a write there is dropped and a read gives zero.
  function automatic bxs_reg_t bxs_decode(input logic [11:0] a);
    bxs_reg_t r;
    r = reg_none;
    if (bxs_is_file(a)) begin
      r = reg_file;
    end else begin
      unique case (a)
        BXS_CMD_OFS: r = reg_cmd;
        BXS_ACC_OFS: r = reg_acc;
        BXS_STAT_OFS: r = reg_stat;
        BXS_RES_OFS: r = reg_res;
        default: r = reg_none;
      endcase
    end
    return r;
  endfunction

  function automatic logic [31:0] bxs_byte_word(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction

  // Status occupies the low three bits; everything above reads as zero.
  function automatic logic [31:0] bxs_flags_to_word(input bxs_flags_t f);
    logic [31:0] w;
    w = BXS_RDATA_RST;
    w[BXS_ST_CARRY] = f.carry;
    w[BXS_ST_HALF] = f.half_borrow_inverse_flag;
    w[BXS_ST_ZERO] = f.zero;
    return w;
  endfunction

  function automatic bxs_flags_t bxs_flags_from_word(input logic [31:0] w);
    bxs_flags_t f;
    f.carry = w[BXS_ST_CARRY];
    f.half_borrow_inverse_flag = w[BXS_ST_HALF];
    f.zero = w[BXS_ST_ZERO];
    return f;
  endfunction

  // Only the low byte of a word carries data; the upper bits always read as zero.
  function automatic logic [31:0] bxs_read_word(input bxs_reg_t r, input bxs_state_t s);
    logic [31:0] w;
    w = BXS_RDATA_RST;
    unique case (r)
      reg_file: w = bxs_byte_word(s.freg[bxs_file_idx(s.addr)]);
      reg_acc: w = bxs_byte_word(s.acc);
      reg_stat: w = bxs_flags_to_word(s.flags);
      reg_res: w = bxs_byte_word(s.last_result);
      default: w = BXS_RDATA_RST;
    endcase
    return w;
  endfunction

  // Command fields sit at fixed positions; the bits between them are ignored.
  function automatic bxs_cmd_t bxs_cmd_from_word(input logic [31:0] w);
    bxs_cmd_t c;
    c.op = bxs_op_t'(w[BXS_CMD_OP_LSB +: 2]);
    c.dest = w[BXS_CMD_DEST_BIT];
    c.faddr = w[BXS_CMD_FADDR_LSB +: 7];
    c.imm = w[BXS_CMD_IMM_LSB +: 8];
    return c;
  endfunction

  // The result always lands in last_result and in one of acc or the file, chosen by the ALU's to_file flag.
  function automatic bxs_state_t bxs_apply_cmd(input bxs_state_t s, input bxs_alu_out_t a,
                                               input logic [6:0] fa);
    bxs_state_t n;
    n = s;
    n.last_result = a.result;
    n.flags = a.flags;
    if (a.to_file) begin
      n.freg[fa] = a.result;
    end else begin
      n.acc = a.result;
    end
    return n;
  endfunction

  // A data-phase write lands in the decoded register, except result, which ignores it; a command runs through the datapath.
  function automatic bxs_state_t bxs_apply_write(input bxs_state_t s, input bxs_reg_t r,
                                                 input logic [31:0] w, input bxs_alu_out_t a,
                                                 input logic [6:0] fa);
    bxs_state_t n;
    n = s;
    unique case (r)
      reg_file: n.freg[bxs_file_idx(s.addr)] = w[7:0];
      reg_cmd: n = bxs_apply_cmd(s, a, fa);
      reg_acc: n.acc = w[7:0];
      reg_stat: n.flags = bxs_flags_from_word(w);
      default: n = s;
    endcase
    return n;
  endfunction

  // ==========================================================================
  // Datapath
  // ==========================================================================
  // The command is decoded straight from write data so it executes in its own data phase.
  always_comb begin
    cmd = bxs_cmd_from_word(hwdata);
    sel_freg = st.freg[cmd.faddr];
  end

  bxs_alu u_alu (
    .cmd(cmd),
    .acc(st.acc),
    .freg_val(sel_freg),
    .flags_in(st.flags),
    .alu_out(alu_out)
  );

  // ==========================================================================
  // Bus slave and register file
  // ==========================================================================
  // Decoding the stored address, not haddr, lets the next address phase overlap this data phase.
  assign accept = hsel && htrans[1] && hready;
  assign reg_sel = bxs_decode(st.addr);

  // One wait state per transfer keeps read data coming straight from a flop.
  always_comb begin
    next_st = st;
    if (st.pend) begin
      if (st.wr) begin
        next_st = bxs_apply_write(st, reg_sel, hwdata, alu_out, cmd.faddr);
      end else begin
        next_st.hrdata = bxs_read_word(reg_sel, st);
      end
      next_st.pend = 1'b0;
      next_st.hreadyout = 1'b1;
    end
    if (accept) begin
      next_st.pend = 1'b1;
      next_st.wr = hwrite;
      next_st.addr = {haddr[11:2], 2'b00};
      next_st.hreadyout = 1'b0;
    end
  end

  // The whole file clears on reset so that a read before any write returns a defined zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.freg <= '{default: BXS_FILE_RST};
      st.acc <= BXS_ACC_RST;
      st.flags <= BXS_FLAGS_RST;
      st.last_result <= BXS_ACC_RST;
      st.pend <= 1'b0;
      st.wr <= 1'b0;
      st.addr <= BXS_CMD_OFS;
      st.hreadyout <= 1'b1;
      st.hrdata <= BXS_RDATA_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The response stays OKAY: no register refuses an access, unmapped ones included.
  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = 1'b0;

endmodule

// [testbench/bxs_chk.sv]
`timescale 1ns/1ps
module bxs_chk
  import bxs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  // ==========================================================================
  // Bus answer checks
  // ==========================================================================
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic rd_stat;
  assign rd_stat = hsel && htrans[1] && hready && !hwrite && haddr[11:0] == BXS_STAT_OFS;

  chk_wait_state: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("accepted transfer did not get exactly one wait state");
  chk_idle_ready: assert property (!(hsel && htrans[1] && hready) |=> hreadyout)
    else $error("hreadyout dropped without an accepted transfer");
  chk_ready_back: assert property (!hreadyout |=> hreadyout)
    else $error("hreadyout stayed low for more than one cycle");
  // Read data may only move at the edge that ends a read, so it must hold otherwise.
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata changed outside a read completion");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp was not OKAY");
  chk_stat_upper: assert property (rd_stat |=> ##1 hrdata[31:3] == 29'h0)
    else $error("status read returned bits above the three flags");
endmodule

bind bxs_top bxs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .hwrite(hwrite), .htrans(htrans), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp));

// [testbench/byte_alu_sub_xor_swap_bench.sv]
`timescale 1ns/1ps
module byte_alu_sub_xor_swap_bench;
  import bxs_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int num_errors = 0;
  int total_checks = 0;

  always #4 hclk = ~hclk;

  bxs_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // The iff samples hreadyout before this edge's updates land, as the bus does.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk iff hreadyout);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk iff hreadyout);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    cmp(n, e, r);
  endtask

  function automatic logic [31:0] fad(input logic [6:0] n);
    return {20'h0, BXS_FILE_BASE} + {23'h0, n, 2'h0};
  endfunction

  // ==========================================================================
  // One operation with its expected outcome
  // ==========================================================================
  task automatic run(input bxs_op_t op, input logic d, input logic [6:0] fa,
                     input logic [7:0] fv, input logic [7:0] av, input logic [7:0] k,
                     input logic [2:0] st);
    logic [7:0] res;
    logic [2:0] fl;
    logic tf;
    wr(fad(fa), {24'h0, fv});
    wr({20'h0, BXS_ACC_OFS}, {24'h0, av});
    wr({20'h0, BXS_STAT_OFS}, {29'h0, st});
    wr({20'h0, BXS_CMD_OFS}, {8'h0, k, 1'b0, fa, 5'h0, d, op});
    fl = st;
    tf = d && op != immediate_xor_op;
    case (op)
      register_minus_accumulator_op: begin
        res = fv - av;
        fl[1:0] = {av[3:0] <= fv[3:0], av <= fv};
      end
      immediate_xor_op: res = av ^ k;
      nibble_exchange_op: res = {fv[3:0], fv[7:4]};
      default: res = av ^ fv;
    endcase
    fl[2] = (op == nibble_exchange_op) ? st[2] : (res == 8'h00);
    rd("acc", {20'h0, BXS_ACC_OFS}, {24'h0, tf ? av : res});
    rd("file", fad(fa), {24'h0, tf ? res : fv});
    rd("result", {20'h0, BXS_RES_OFS}, {24'h0, res});
    rd("status", {20'h0, BXS_STAT_OFS}, {29'h0, fl});
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("file_rst", fad(7'h7f), 32'h0);
    rd("unmapped", 32'h0000_0100, 32'h0);
    run(register_minus_accumulator_op, 1'b0, 7'h05, 8'h37, 8'h12, 8'h00, 3'h0);
    run(register_minus_accumulator_op, 1'b1, 7'h7f, 8'h48, 8'h48, 8'h00, 3'h0);
    run(register_minus_accumulator_op, 1'b0, 7'h00, 8'h10, 8'h21, 8'h00, 3'h7);
    run(register_minus_accumulator_op, 1'b1, 7'h33, 8'h2f, 8'h1f, 8'h00, 3'h4);
    run(immediate_xor_op, 1'b1, 7'h01, 8'h99, 8'h5a, 8'h5a, 3'h3);
    run(immediate_xor_op, 1'b0, 7'h02, 8'h00, 8'hff, 8'h0f, 3'h4);
    run(nibble_exchange_op, 1'b0, 7'h40, 8'ha5, 8'h11, 8'h00, 3'h5);
    run(nibble_exchange_op, 1'b1, 7'h7f, 8'h3c, 8'h00, 8'h00, 3'h2);
    run(register_xor_op, 1'b1, 7'h22, 8'hc3, 8'hc3, 8'h00, 3'h3);
    run(register_xor_op, 1'b0, 7'h23, 8'hc3, 8'h0f, 8'h00, 3'h7);
    finish_test();
  end

  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule
